//--- rtl/adc_output_config_pkg.sv
// constants for the output configuration register bank
// used by the bank; the host model and bench repeat these values as literals
package adc_output_config_pkg;

   // register offsets on the serial control port
   localparam logic [7:0] SAMPLE_FORMAT_OFS  = 8'h14;
   localparam logic [7:0] DRIVER_STRENGTH_OFS = 8'h15;
   localparam logic [7:0] CLOCK_PHASE_OFS    = 8'h16;
   localparam logic [7:0] PATTERN_A_LOW_OFS  = 8'h19;
   localparam logic [7:0] PATTERN_A_HIGH_OFS = 8'h1A;
   localparam logic [7:0] PATTERN_B_LOW_OFS  = 8'h1B;
   localparam logic [7:0] PATTERN_B_HIGH_OFS = 8'h1C;
   localparam logic [7:0] DEVICE_UPDATE_OFS  = 8'hFF;

   // values after reset
   localparam logic [7:0] SAMPLE_FORMAT_RST   = 8'h00;
   localparam logic [7:0] DRIVER_STRENGTH_RST = 8'h00;
   localparam logic [7:0] CLOCK_PHASE_RST     = 8'h03;
   localparam logic [7:0] PATTERN_RST         = 8'h00;

   // implemented bits of the format, drive and phase registers, the rest read zero
   localparam logic [7:0] SAMPLE_FORMAT_MASK   = 8'h47;
   localparam logic [7:0] DRIVER_STRENGTH_MASK = 8'h31;
   localparam logic [7:0] CLOCK_PHASE_MASK     = 8'h0F;

   // field positions
   localparam int FORMAT_LSB      = 0;
   localparam int INVERT_BIT      = 2;
   localparam int LOW_POWER_BIT   = 6;
   localparam int DRIVE_2X_BIT    = 0;
   localparam int TERM_LSB        = 4;
   localparam int SW_TRANSFER_BIT = 0;

   // encodings
   localparam logic [1:0] FORMAT_OFFSET_BIN = 2'h0;
   localparam logic [1:0] FORMAT_TWOS_COMP  = 2'h1;
   localparam logic [3:0] PHASE_CODE_MAX    = 4'hA;
   localparam logic [3:0] TEST_MODE_USER    = 4'h8;
   localparam logic [9:0] PHASE_STEP_DEG    = 10'h03C;

   // widths
   localparam int SAMPLE_W    = 14;
   localparam int WORD_W      = 16;
   localparam int PHASE_TAPS  = 11;

endpackage

//--- rtl/adc_output_config_regs.sv
// output configuration register bank with master and active copies
// assumes a serial port decoder on sys_clk that issues one-cycle
// read and write strobes, and a divider giving phase taps on sys_clk
`timescale 1ns/1ps

module adc_output_config_regs
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // serial control port register access
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   output logic      [7:0]  regRdData,
   output logic             regRdValid,
   // sample path
   input  wire logic [13:0] sampleIn,
   input  wire logic        sampleStrobe,
   input  wire logic [3:0]  testModeSel,
   output logic      [15:0] dataOut,
   output logic             dataValid,
   // output clocking
   input  wire logic [10:0] divPhaseTap,
   output logic             bitClockOut,
   output logic             bitClockDrive2x,
   output logic             frameClockDrive2x,
   output logic      [9:0]  phaseOffsetDeg,
   output logic      [1:0]  termSelect,
   output logic             lowPowerLvds
);

   // ---------------- register access ----------------
   logic [7:0] mFormat, mDrive, mPhase, mPatAL, mPatAH, mPatBL, mPatBH;
   logic [7:0] sFormat, sDrive, sPhase, sPatAL, sPatAH, sPatBL, sPatBH;
   logic [7:0] next_mFormat, next_mDrive, next_mPhase;
   logic [7:0] next_mPatAL, next_mPatAH, next_mPatBL, next_mPatBH;
   logic [7:0] next_sFormat, next_sDrive, next_sPhase;
   logic [7:0] next_sPatAL, next_sPatAH, next_sPatBL, next_sPatBH;
   logic [7:0] next_regRdData;
   logic       next_regRdValid;
   logic       swTransfer;

   assign swTransfer = regWrEn && (regAddr == adc_output_config_pkg::DEVICE_UPDATE_OFS)
                       && regWrData[adc_output_config_pkg::SW_TRANSFER_BIT];

   always_comb
   begin
      next_mFormat = mFormat;
      next_mDrive  = mDrive;
      next_mPhase  = mPhase;
      next_mPatAL  = mPatAL;
      next_mPatAH  = mPatAH;
      next_mPatBL  = mPatBL;
      next_mPatBH  = mPatBH;
      if (regWrEn)
      begin
         // writes only reach the master copy
         unique case (regAddr)
            adc_output_config_pkg::SAMPLE_FORMAT_OFS:
               next_mFormat = regWrData & adc_output_config_pkg::SAMPLE_FORMAT_MASK;
            adc_output_config_pkg::DRIVER_STRENGTH_OFS:
               next_mDrive = regWrData & adc_output_config_pkg::DRIVER_STRENGTH_MASK;
            adc_output_config_pkg::CLOCK_PHASE_OFS:
               next_mPhase = regWrData & adc_output_config_pkg::CLOCK_PHASE_MASK;
            adc_output_config_pkg::PATTERN_A_LOW_OFS:  next_mPatAL = regWrData;
            adc_output_config_pkg::PATTERN_A_HIGH_OFS: next_mPatAH = regWrData;
            adc_output_config_pkg::PATTERN_B_LOW_OFS:  next_mPatBL = regWrData;
            adc_output_config_pkg::PATTERN_B_HIGH_OFS: next_mPatBH = regWrData;
            default:
            begin
            end
         endcase
      end
   end

   always_comb
   begin
      next_sFormat = sFormat;
      next_sDrive  = sDrive;
      next_sPhase  = sPhase;
      next_sPatAL  = sPatAL;
      next_sPatAH  = sPatAH;
      next_sPatBL  = sPatBL;
      next_sPatBH  = sPatBH;
      if (swTransfer)
      begin
         // all fields move together so the output never sees a half update
         next_sFormat = mFormat;
         next_sDrive  = mDrive;
         next_sPhase  = mPhase;
         next_sPatAL  = mPatAL;
         next_sPatAH  = mPatAH;
         next_sPatBL  = mPatBL;
         next_sPatBH  = mPatBH;
      end
   end

   always_comb
   begin
      next_regRdValid = regRdEn;
      next_regRdData  = 8'h00;
      if (regRdEn)
      begin
         unique case (regAddr)
            adc_output_config_pkg::SAMPLE_FORMAT_OFS:   next_regRdData = mFormat;
            adc_output_config_pkg::DRIVER_STRENGTH_OFS: next_regRdData = mDrive;
            adc_output_config_pkg::CLOCK_PHASE_OFS:     next_regRdData = mPhase;
            adc_output_config_pkg::PATTERN_A_LOW_OFS:   next_regRdData = mPatAL;
            adc_output_config_pkg::PATTERN_A_HIGH_OFS:  next_regRdData = mPatAH;
            adc_output_config_pkg::PATTERN_B_LOW_OFS:   next_regRdData = mPatBL;
            adc_output_config_pkg::PATTERN_B_HIGH_OFS:  next_regRdData = mPatBH;
            // transfer bit is self clearing, other addresses are not ours
            default:                                    next_regRdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         mFormat    <= adc_output_config_pkg::SAMPLE_FORMAT_RST;
         mDrive     <= adc_output_config_pkg::DRIVER_STRENGTH_RST;
         mPhase     <= adc_output_config_pkg::CLOCK_PHASE_RST;
         mPatAL     <= adc_output_config_pkg::PATTERN_RST;
         mPatAH     <= adc_output_config_pkg::PATTERN_RST;
         mPatBL     <= adc_output_config_pkg::PATTERN_RST;
         mPatBH     <= adc_output_config_pkg::PATTERN_RST;
         sFormat    <= adc_output_config_pkg::SAMPLE_FORMAT_RST;
         sDrive     <= adc_output_config_pkg::DRIVER_STRENGTH_RST;
         sPhase     <= adc_output_config_pkg::CLOCK_PHASE_RST;
         sPatAL     <= adc_output_config_pkg::PATTERN_RST;
         sPatAH     <= adc_output_config_pkg::PATTERN_RST;
         sPatBL     <= adc_output_config_pkg::PATTERN_RST;
         sPatBH     <= adc_output_config_pkg::PATTERN_RST;
         regRdData  <= 8'h00;
         regRdValid <= 1'b0;
      end
      else
      begin
         mFormat    <= next_mFormat;
         mDrive     <= next_mDrive;
         mPhase     <= next_mPhase;
         mPatAL     <= next_mPatAL;
         mPatAH     <= next_mPatAH;
         mPatBL     <= next_mPatBL;
         mPatBH     <= next_mPatBH;
         sFormat    <= next_sFormat;
         sDrive     <= next_sDrive;
         sPhase     <= next_sPhase;
         sPatAL     <= next_sPatAL;
         sPatAH     <= next_sPatAH;
         sPatBL     <= next_sPatBL;
         sPatBH     <= next_sPatBH;
         regRdData  <= next_regRdData;
         regRdValid <= next_regRdValid;
      end
   end

   // ---------------- static controls ----------------
   logic [3:0] phaseIdx;

   assign bitClockDrive2x   = sDrive[adc_output_config_pkg::DRIVE_2X_BIT];
   assign frameClockDrive2x = sDrive[adc_output_config_pkg::DRIVE_2X_BIT];
   assign termSelect        = sDrive[adc_output_config_pkg::TERM_LSB +: 2];
   assign lowPowerLvds      = sFormat[adc_output_config_pkg::LOW_POWER_BIT];
   // out of range codes fall back to the reset phase rather than a dead tap
   assign phaseIdx = (sPhase[3:0] > adc_output_config_pkg::PHASE_CODE_MAX)
                     ? adc_output_config_pkg::CLOCK_PHASE_RST[3:0] : sPhase[3:0];
   assign phaseOffsetDeg = 10'(phaseIdx) * adc_output_config_pkg::PHASE_STEP_DEG;

   // ---------------- bit clock tap ----------------
   logic next_bitClockOut;

   always_comb
   begin
      next_bitClockOut = divPhaseTap[phaseIdx];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         bitClockOut <= 1'b0;
      else
         bitClockOut <= next_bitClockOut;
   end

   // ---------------- sample path ----------------
   logic [15:0] next_dataOut;
   logic        next_dataValid;
   logic        patSel;
   logic        next_patSel;
   logic [15:0] word;

   always_comb
   begin
      word           = 16'h0000;
      next_dataOut   = dataOut;
      next_dataValid = sampleStrobe;
      next_patSel    = patSel;
      if (sampleStrobe)
      begin
         if (testModeSel == adc_output_config_pkg::TEST_MODE_USER)
         begin
            // patterns alternate A then B on successive samples
            word        = patSel ? {sPatBH, sPatBL} : {sPatAH, sPatAL};
            next_patSel = ~patSel;
         end
         else
         begin
            word        = {sampleIn, 2'b00};
            next_patSel = 1'b0;
            if (sFormat[adc_output_config_pkg::FORMAT_LSB +: 2] == adc_output_config_pkg::FORMAT_TWOS_COMP)
               word[15] = ~word[15];
         end
         if (sFormat[adc_output_config_pkg::INVERT_BIT])
            word = ~word;
         next_dataOut = word;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         dataOut   <= 16'h0000;
         dataValid <= 1'b0;
         patSel    <= 1'b0;
      end
      else
      begin
         dataOut   <= next_dataOut;
         dataValid <= next_dataValid;
         patSel    <= next_patSel;
      end
   end

   // ---------------- assertions ----------------
   xfer_copy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      swTransfer |=> (sPhase == $past(mPhase)) && (sPatAL == $past(mPatAL)) && (sPatBH == $past(mPatBH)))
      else $error("transfer did not copy master to active");

   slave_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !swTransfer |=> $stable(sFormat) && $stable(sPhase) && $stable(sDrive))
      else $error("active register changed without transfer");

   phase_reset_a: assert property (@(posedge sys_clk)
      !rstn |=> (sPhase == 8'h03) && (mPhase == 8'h03) && (phaseOffsetDeg == 10'h0B4))
      else $error("phase not at 180 degrees after reset");

   pattern_reset_a: assert property (@(posedge sys_clk)
      !rstn |=> ({mPatAH, mPatAL, mPatBH, mPatBL} == 32'h00000000))
      else $error("patterns not zero after reset");

   phase_degree_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (sPhase[3:0] <= 4'hA) |-> (phaseOffsetDeg == 10'(sPhase[3:0]) * 10'h03C))
      else $error("phase degrees wrong");

   tap_select_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      ##1 bitClockOut == $past(divPhaseTap[phaseIdx]))
      else $error("bit clock from wrong tap");

   drive_double_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (swTransfer && mDrive[0]) |=> bitClockDrive2x && frameClockDrive2x)
      else $error("2x drive not applied");

   // a strobe never lands on the very edge of a phase commit in practice,
   // so every strobe and every phase change is checked on its own
   latch_timing_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (sampleStrobe || $changed(sPhase)) |=> (dataValid == $past(sampleStrobe)))
      else $error("phase change disturbed sample latching");

   twos_comp_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      sampleStrobe && (testModeSel != 4'h8) && (sFormat[2:0] == 3'b001)
      |=> dataOut == {~$past(sampleIn[13]), $past(sampleIn[12:0]), 2'b00})
      else $error("twos complement format wrong");

   invert_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      sampleStrobe && (testModeSel != 4'h8) && (sFormat[2:0] == 3'b100)
      |=> dataOut == ~{$past(sampleIn), 2'b00})
      else $error("inverted offset binary wrong");

   user_pattern_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      sampleStrobe && (testModeSel == 4'h8) && !sFormat[2] && !patSel
      |=> dataOut == {sPatAH, sPatAL})
      else $error("user pattern A not on output");

   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      regRdEn && (regAddr == 8'h16) |=> regRdValid && (regRdData[7:4] == 4'h0))
      else $error("reserved phase bits not zero");

endmodule

//--- verification/sp_host_model.sv
// host side of the serial control port, as seen by the register bank
// assumes one sys_clk domain and a read answer one cycle after the strobe
`timescale 1ns/1ps
module sp_host_model
(
   // clock
   input  wire logic       sys_clk,
   // register access toward the bank
   output logic      [7:0] regAddr,
   output logic      [7:0] regWrData,
   output logic            regWrEn,
   output logic            regRdEn,
   input  wire logic [7:0] regRdData,
   input  wire logic       regRdValid
);
   initial
   begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
      // idle bus carries junk, so a stale value never passes for data
      regWrData <= ~d;
      regAddr <= ~a;
   endtask

   // writes only reach the master copy until this is sent
   task automatic xfer();
      wr(8'hFF, 8'h01);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      #1;
      d = (regRdValid === 1'b1) ? regRdData : 8'hXX;
   endtask
endmodule

//--- verification/tb_top.sv
// self-checking bench for the output configuration register bank
// assumes the host model in sp_host_model.sv and one 25 MHz clock
`timescale 1ns/1ps
module tb_top;
   logic        sys_clk = 1'b0;
   logic        rstn;
   logic [7:0]  regAddr;
   logic [7:0]  regWrData;
   logic        regWrEn;
   logic        regRdEn;
   logic [7:0]  regRdData;
   logic        regRdValid;
   logic [13:0] sampleIn;
   logic        sampleStrobe;
   logic [3:0]  testModeSel;
   logic [15:0] dataOut;
   logic        dataValid;
   logic [10:0] divPhaseTap;
   logic        bitClockOut;
   logic        bitClockDrive2x;
   logic        frameClockDrive2x;
   logic [9:0]  phaseOffsetDeg;
   logic [1:0]  termSelect;
   logic        lowPowerLvds;
   int          errors;
   int          checked;
   logic [7:0]  rdVal;
   logic [15:0] expWord;
   logic [15:0] prevDeg;
   logic [7:0]  addrs [7] = '{8'h14, 8'h15, 8'h16, 8'h19, 8'h1A, 8'h1B, 8'h1C};
   logic [7:0]  pb [4] = '{8'h34, 8'h12, 8'hCD, 8'hAB};

   adc_output_config_regs dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
      .sampleIn(sampleIn), .sampleStrobe(sampleStrobe), .testModeSel(testModeSel), .dataOut(dataOut),
      .dataValid(dataValid), .divPhaseTap(divPhaseTap), .bitClockOut(bitClockOut),
      .bitClockDrive2x(bitClockDrive2x), .frameClockDrive2x(frameClockDrive2x),
      .phaseOffsetDeg(phaseOffsetDeg), .termSelect(termSelect), .lowPowerLvds(lowPowerLvds));

   sp_host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));

   always #20 sys_clk = ~sys_clk;

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, rdVal);
      chk("regRdData", {8'h00, exp}, {8'h00, rdVal});
   endtask

   // active copy updates on the transfer edge; let it settle
   task automatic commit();
      host.xfer();
      #1;
   endtask

   task automatic smp(input logic [13:0] v, input logic [15:0] exp);
      @(posedge sys_clk);
      sampleIn <= v;
      sampleStrobe <= 1'b1;
      @(posedge sys_clk);
      sampleStrobe <= 1'b0;
      sampleIn <= ~v;
      #1;
      chk("dataValid", 16'h0001, {15'h0000, dataValid});
      chk("dataOut", exp, dataOut);
   endtask

   task automatic end_of_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      #(40 * 20000);
      errors++;
      end_of_test();
   end

   initial
   begin
      rstn = 1'b0;
      sampleIn = 14'h0000;
      sampleStrobe = 1'b0;
      testModeSel = 4'h0;
      divPhaseTap = 11'h000;
      errors = 0;
      checked = 0;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      chk("phaseOffsetDeg", 16'h00B4, {6'h00, phaseOffsetDeg});
      for (int i = 0; i < 7; i++)
         rdchk(addrs[i], (i == 2) ? 8'h03 : 8'h00);
      rdchk(8'h20, 8'h00);
      rdchk(8'hFF, 8'h00);
      for (int i = 0; i < 3; i++)
         host.wr(addrs[i], 8'hFF);
      rdchk(8'h14, 8'h47);
      rdchk(8'h15, 8'h31);
      rdchk(8'h16, 8'h0F);
      chk("bitClockDrive2x", 16'h0000, {15'h0000, bitClockDrive2x});
      commit();
      chk("drive2x", 16'h0003, {14'h0000, bitClockDrive2x, frameClockDrive2x});
      chk("termLowPower", 16'h0007, {13'h0000, termSelect, lowPowerLvds});
      chk("phaseOffsetDeg", 16'h00B4, {6'h00, phaseOffsetDeg});
      host.wr(8'h15, 8'h00);
      host.wr(8'h14, 8'h00);
      commit();
      chk("drive2x", 16'h0000, {14'h0000, bitClockDrive2x, frameClockDrive2x});
      prevDeg = 16'h00B4;
      for (int c = 0; c < 12; c++)
      begin
         host.wr(8'h16, 8'(c));
         chk("phaseOffsetDeg", prevDeg, {6'h00, phaseOffsetDeg});
         commit();
         prevDeg = (c > 10) ? 16'h00B4 : 16'(c * 16'h003C);
         chk("phaseOffsetDeg", prevDeg, {6'h00, phaseOffsetDeg});
         smp(14'h0000, 16'h0000);
         // taps move on a clock edge like every other input
         @(posedge sys_clk);
         divPhaseTap <= 11'h001 << ((c > 10) ? 3 : c);
         repeat (2) @(posedge sys_clk);
         #1;
         chk("bitClockOut", 16'h0001, {15'h0000, bitClockOut});
         @(posedge sys_clk);
         divPhaseTap <= ~(11'h001 << ((c > 10) ? 3 : c));
         repeat (2) @(posedge sys_clk);
         #1;
         chk("bitClockOut", 16'h0000, {15'h0000, bitClockOut});
      end
      for (int f = 0; f < 8; f++)
      begin
         host.wr(8'h14, {5'h00, f[2:0]});
         commit();
         expWord = {14'h1ABC, 2'h0};
         if (f[1:0] == 2'h1)
            expWord[15] = ~expWord[15];
         if (f[2])
            expWord = ~expWord;
         smp(14'h1ABC, expWord);
      end
      host.wr(8'h14, 8'h00);
      for (int i = 0; i < 4; i++)
         host.wr(addrs[3 + i], pb[i]);
      commit();
      for (int i = 0; i < 4; i++)
         rdchk(addrs[3 + i], pb[i]);
      @(posedge sys_clk);
      testModeSel <= 4'h8;
      smp(14'h0000, 16'h1234);
      smp(14'h0000, 16'hABCD);
      smp(14'h0000, 16'h1234);
      @(posedge sys_clk);
      testModeSel <= 4'h0;
      smp(14'h0001, 16'h0004);
      @(posedge sys_clk);
      testModeSel <= 4'h8;
      smp(14'h0000, 16'h1234);
      host.wr(8'h14, 8'h04);
      commit();
      smp(14'h0000, 16'h5432);
      end_of_test();
   end
endmodule
